// *** verilog/dma_resp_pkg.sv ***
// Package: types and constants for the DMA channel response controller
// Assumes a single 50 MHz system clock domain
package dma_resp_pkg;
    localparam logic [1:0] RESP_SINGLE     = 2'h0;
    localparam logic [1:0] RESP_BUS_HOLD   = 2'h1;
    localparam logic [1:0] RESP_BUS_REL    = 2'h2;
    localparam logic [1:0] RESP_INTERLEAVE = 2'h3;
    localparam logic [1:0] OP_TRANSFER     = 2'h0;
    localparam logic [1:0] OP_TRANSFER_SRC = 2'h1;
    localparam logic [1:0] OP_SEARCH       = 2'h2;
    localparam logic [1:0] FUN_NONE        = 2'h0;
    localparam logic [1:0] FUN_BYTE_WORD   = 2'h1;
    localparam logic [1:0] FUN_WORD_BYTE   = 2'h2;
    localparam int         DATA_W          = 16;
    localparam int         COUNT_W         = 16;
    localparam int         ADDR_W          = 24;
    localparam int         FIFO_DEPTH      = 4;
    localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000;
    localparam logic [ADDR_W-1:0]  ADDR_STEP  = 24'h000001;

    typedef enum logic [3:0] {
        ST_IDLE     = 4'b0000,
        ST_REQ_BUS  = 4'b0001,
        ST_READ     = 4'b0010,
        ST_WRITE    = 4'b0011,
        ST_DECIDE   = 4'b0100,
        ST_IDLE_HLD = 4'b0101,
        ST_TERM     = 4'b0110,
        ST_SIP_WAIT = 4'b0111,
        ST_RELOAD   = 4'b1000,
        ST_RELEASE  = 4'b1001
    } chan_state_t;

    typedef struct packed {
        logic [1:0] response_select_field;
        logic [1:0] op_kind;
        logic [1:0] funnel;
        logic       flyby;
        logic       ack_waveform_select;
        logic       step_a;
        logic       step_b;
        logic       chain_enable;
        logic       reload_enable;
    } chan_cfg_t;

    typedef struct packed {
        logic [DATA_W-1:0] pattern;
        logic [DATA_W-1:0] mask;
        logic              stop_on_match;
    } match_cfg_t;
endpackage : dma_resp_pkg

// *** verilog/dma_channel_request_response.sv ***
// DMA channel request/response and bus tenure controller with data FIFO
// Assumes synchronous inputs on sys_clk and an arbiter granting bus_grant
// Overview of operation
// - Response field picks single operation, bus hold, bus release or interleave.
// - Search iteration is one read, compare, count decrement, optional address step.
// - Transfer iteration reads source, writes destination, steps both addresses; funnelling varies.
// - Iteration never ends before held data reaches the destination.
// - Single mode: each software request, or chained request bit, runs one iteration.
// - Single mode: each request falling edge runs one iteration, deferred while masked.
// - Single mode releases bus unless new edge seen after iteration's first read.
// - Bus hold: software, chained or low request acquires bus; software runs to termination.
// - Level acknowledge is active from bus acquisition to bus release.
// - Bus hold sampled each slot: low iterates, high idles holding bus.
// - Bus hold releases after termination and reload unless requests remain.
// - Bus release: software or chained request runs to termination without release.
// - Bus release: low request iterates until termination or high; chain end sampled.
// - Termination in bus release reloads or chains without release if hold bit clear.
// - Hold bit set at termination releases bus until acknowledged, then re-requests bus if chain or reload set.
// - No request: bus hold idles holding bus; other demand modes release.
// - Interleave with policy bit set releases and re-requests after every iteration.
// - Interleave with policy bit clear also releases, flagging yield_to_other when the other channel requests.
// - Interleave chain end with low request runs one iteration then interleaves.
// - Waveform bit selects level or pulsed acknowledge; pulsed only for flyby.
// - Count reaching zero before a match raises count exhaustion termination.
`timescale 1ns/1ps
module dma_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      fill;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;
    assign in_ready  = (fill != (AW+1)'(DEPTH));
    assign out_valid = (fill != '0);
    assign out_data  = mem[rd_ptr];
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end
        else
        begin
            if (push)
            begin
                mem[wr_ptr] <= in_data;
                wr_ptr      <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop)
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : dma_fifo

module dma_channel_request_response
    import dma_resp_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire chan_cfg_t         cfg,
    input  wire match_cfg_t        match_cfg,
    input  wire logic              master_release_policy_bit,
    input  wire logic              sw_request,
    input  wire logic              chain_sets_sw_request,
    input  wire logic              hw_mask,
    input  wire logic              interrupt_pending_hold,
    input  wire logic              interrupt_ack,
    input  wire logic              dma_request_n,
    input  wire logic              end_of_process_n,
    input  wire logic [COUNT_W-1:0] count_load,
    input  wire logic [ADDR_W-1:0] addr_a_load,
    input  wire logic [ADDR_W-1:0] addr_b_load,
    input  wire logic              load_strobe,
    input  wire logic              other_chan_request,
    input  wire logic              bus_grant,
    input  wire logic              access_done,
    input  wire logic [DATA_W-1:0] read_data,
    output logic                   bus_request,
    output logic                   bus_owned,
    output logic                   read_strobe,
    output logic                   write_strobe,
    output logic [ADDR_W-1:0]      bus_address,
    output logic [DATA_W-1:0]      write_data,
    output logic                   dma_acknowledge_n,
    output logic                   idle_hold_state,
    output logic                   count_exhausted,
    output logic                   match_found,
    output logic                   eop_seen,
    output logic                   reload_request,
    output logic                   yield_to_other,
    output logic [COUNT_W-1:0]     op_count,
    output logic [ADDR_W-1:0]      current_address_a,
    output logic [ADDR_W-1:0]      current_address_b
);
    chan_state_t      state;
    chan_state_t      next_state;
    logic             req_n_prev;
    logic             edge_pend;
    logic             sw_pend;
    logic             sw_run;
    logic             terminated;
    logic [1:0]       reads_left;
    logic [1:0]       writes_left;
    logic             ack_pulse;
    logic             fifo_in_ready;
    logic             fifo_out_valid;
    logic [DATA_W-1:0] fifo_out_data;

    function automatic logic is_match(input logic [DATA_W-1:0] d, input match_cfg_t m);
        logic eq;
        eq = (((d ^ m.pattern) & ~m.mask) == '0);
        return m.stop_on_match ? eq : !eq;
    endfunction : is_match

    wire is_search   = (cfg.op_kind == OP_SEARCH);
    wire is_single   = (cfg.response_select_field == RESP_SINGLE);
    wire is_hold     = (cfg.response_select_field == RESP_BUS_HOLD);
    wire is_inter    = (cfg.response_select_field == RESP_INTERLEAVE);
    wire req_low     = !dma_request_n;
    wire req_fall    = req_n_prev && !dma_request_n;
    wire in_read     = (state == ST_READ);
    wire read_taken  = in_read && access_done && fifo_in_ready;
    wire write_taken = (state == ST_WRITE) && access_done && fifo_out_valid;
    wire rd_match    = read_taken && (cfg.op_kind != OP_TRANSFER) && is_match(read_data, match_cfg);
    wire eop_now     = !end_of_process_n;
    wire last_read   = read_taken && (reads_left == 2'h1);
    wire count_last  = (op_count == COUNT_W'(1) || op_count == COUNT_ZERO);
    wire iter_end    = (is_search || cfg.flyby) ? last_read
                     : (write_taken && writes_left == 2'h1);
    wire term_hit    = iter_end && (count_last || terminated || match_found || rd_match || eop_seen);
    wire any_sw      = sw_pend || chain_sets_sw_request;
    wire want_start  = any_sw || sw_run || (is_single ? (edge_pend && !hw_mask) : req_low);
    wire more_demand = sw_run || (is_single ? (edge_pend && !hw_mask) : req_low);

    assign read_strobe  = in_read;
    assign write_strobe = (state == ST_WRITE) && fifo_out_valid && !cfg.flyby;
    assign write_data   = fifo_out_data;
    assign bus_address  = in_read ? current_address_a : current_address_b;
    assign bus_request  = (state == ST_REQ_BUS);
    assign bus_owned    = !(state == ST_IDLE || state == ST_REQ_BUS || state == ST_SIP_WAIT);
    assign idle_hold_state = (state == ST_IDLE_HLD);

    // Acknowledge waveform: level during tenure, pulse for flyby only
    assign dma_acknowledge_n = cfg.ack_waveform_select
                             ? !(cfg.flyby && ack_pulse)
                             : !bus_owned;

    dma_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .in_data   (read_data),
        .in_valid  (last_read && !is_search && !cfg.flyby),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_data),
        .out_valid (fifo_out_valid),
        .out_ready (write_taken && writes_left == 2'h1)
    );

    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (want_start)
                    next_state = ST_REQ_BUS;
            ST_REQ_BUS:
                if (bus_grant)
                    next_state = ST_READ;
            ST_READ:
                if (read_taken && (reads_left == 2'h1))
                    next_state = (is_search || cfg.flyby) ? ST_DECIDE : ST_WRITE;
            ST_WRITE:
                if (write_taken && writes_left == 2'h1)
                    next_state = ST_DECIDE;
            ST_DECIDE:
                if (terminated)
                    next_state = ST_TERM;
                else if (is_single)
                    next_state = (any_sw || (edge_pend && !hw_mask)) ? ST_READ : ST_RELEASE;
                else if (is_inter)
                    next_state = ST_RELEASE;
                else if (more_demand)
                    next_state = ST_READ;
                else if (is_hold)
                    next_state = ST_IDLE_HLD;
                else
                    next_state = ST_RELEASE;
            ST_IDLE_HLD:
                if (req_low || any_sw)
                    next_state = ST_READ;
            ST_TERM:
                if (interrupt_pending_hold)
                    next_state = ST_SIP_WAIT;
                else if (cfg.chain_enable || cfg.reload_enable)
                    next_state = ST_RELOAD;
                else
                    next_state = ST_RELEASE;
            ST_SIP_WAIT:
                if (interrupt_ack && !interrupt_pending_hold)
                    next_state = (cfg.chain_enable || cfg.reload_enable) ? ST_REQ_BUS : ST_IDLE;
            ST_RELOAD:
                if (load_strobe)
                    next_state = (any_sw || (!is_single && req_low)) ? ST_READ : ST_RELEASE;
            ST_RELEASE:
                next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    wire iter_start = (next_state == ST_READ) && (state != ST_READ);
    wire [1:0] reads_init  = (cfg.funnel == FUN_BYTE_WORD) ? 2'h2 : 2'h1;
    wire [1:0] writes_init = (cfg.funnel == FUN_WORD_BYTE) ? 2'h2 : 2'h1;

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            state      <= ST_IDLE;
            req_n_prev <= 1'b1;
            edge_pend  <= 1'b0;
            sw_pend    <= 1'b0;
            sw_run     <= 1'b0;
            terminated <= 1'b0;
            reads_left <= 2'h0;
            writes_left <= 2'h0;
            ack_pulse  <= 1'b0;
            count_exhausted <= 1'b0;
            match_found <= 1'b0;
            eop_seen   <= 1'b0;
            reload_request <= 1'b0;
            yield_to_other <= 1'b0;
            op_count   <= COUNT_ZERO;
            current_address_a <= '0;
            current_address_b <= '0;
        end
        else
        begin
            state      <= next_state;
            req_n_prev <= dma_request_n;
            // Edge pending: set wins, consumed at iteration start
            if (req_fall && (is_single && (state != ST_READ || reads_left != reads_init || !in_read)))
                edge_pend <= 1'b1;
            else if (iter_start && !any_sw)
                edge_pend <= 1'b0;
            else if (terminated && state == ST_RELEASE)
                edge_pend <= 1'b0;
            if (sw_request || chain_sets_sw_request)
                sw_pend <= 1'b1;
            else if (iter_start)
                sw_pend <= 1'b0;
            if (iter_start && any_sw && !is_single)
                sw_run <= 1'b1;
            else if (state == ST_TERM)
                sw_run <= 1'b0;
            if (iter_start)
            begin
                reads_left  <= reads_init;
                writes_left <= writes_init;
            end
            else
            begin
                if (read_taken)
                    reads_left <= reads_left - 2'h1;
                if (write_taken)
                    writes_left <= writes_left - 2'h1;
            end
            ack_pulse <= read_taken && cfg.flyby;
            if (load_strobe)
            begin
                op_count          <= count_load;
                current_address_a <= addr_a_load;
                current_address_b <= addr_b_load;
            end
            else
            begin
                if (read_taken && cfg.step_a)
                    current_address_a <= current_address_a + ADDR_STEP;
                if ((write_taken || (cfg.flyby && read_taken)) && cfg.step_b && !is_search)
                    current_address_b <= current_address_b + ADDR_STEP;
                if (iter_end && op_count != COUNT_ZERO)
                    op_count <= op_count - 16'h0001;
            end
            if (rd_match)
                match_found <= 1'b1;
            else if (iter_start && state != ST_DECIDE)
                match_found <= 1'b0;
            if (eop_now && bus_owned)
                eop_seen <= 1'b1;
            else if (load_strobe)
                eop_seen <= 1'b0;
            if (term_hit && !match_found && !rd_match && count_last)
                count_exhausted <= 1'b1;
            else if (load_strobe)
                count_exhausted <= 1'b0;
            if (term_hit)
                terminated <= 1'b1;
            else if (load_strobe || state == ST_IDLE)
                terminated <= 1'b0;
            reload_request <= (next_state == ST_RELOAD);
            yield_to_other <= (state == ST_DECIDE) && is_inter && !master_release_policy_bit
                              && other_chan_request;
        end
    end
endmodule : dma_channel_request_response

// *** dv/dma_resp_sva.sv ***
// Checker: tenure, acknowledge and count properties of the channel
// Assumes binding to the controller top, single sys_clk domain
`timescale 1ns/1ps
module dma_resp_sva
    import dma_resp_pkg::*;
(
    input wire logic               sys_clk,
    input wire logic               nrst,
    input wire chan_cfg_t          cfg,
    input wire logic               load_strobe,
    input wire logic               dma_request_n,
    input wire logic               end_of_process_n,
    input wire logic               bus_owned,
    input wire logic               read_strobe,
    input wire logic               write_strobe,
    input wire logic               dma_acknowledge_n,
    input wire logic               idle_hold_state,
    input wire logic               count_exhausted,
    input wire logic               eop_seen,
    input wire logic [COUNT_W-1:0] op_count
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    a_ack_level: assert property (!cfg.ack_waveform_select |-> dma_acknowledge_n == !bus_owned)
        else $error("level acknowledge differs from bus tenure");
    a_pulse_quiet: assert property (cfg.ack_waveform_select && !cfg.flyby |-> dma_acknowledge_n)
        else $error("pulsed acknowledge active outside flyby");
    a_strobe_owned: assert property (read_strobe || write_strobe |-> bus_owned)
        else $error("bus access without bus ownership");
    a_hold_idle: assert property (idle_hold_state |-> bus_owned && !read_strobe && !write_strobe)
        else $error("idle hold state without held quiet bus");
    a_count_step: assert property (!$past(load_strobe) && $changed(op_count)
        |-> op_count == $past(op_count) - 16'h0001)
        else $error("operation count moved by other than one");
    a_exhaust_zero: assert property ($rose(count_exhausted) |-> op_count == COUNT_ZERO)
        else $error("count exhaustion with nonzero count");
    a_hold_release: assert property (cfg.response_select_field == RESP_BUS_HOLD && $rose(count_exhausted)
        && dma_request_n && !cfg.reload_enable && !cfg.chain_enable |-> ##[1:10] !bus_owned)
        else $error("bus hold kept bus after termination");
    a_leave_interleave: assert property (cfg.response_select_field == RESP_INTERLEAVE
        && $rose(bus_owned) |-> ##[1:60] !bus_owned)
        else $error("interleave channel kept the bus");
    a_eop_flag: assert property ($fell(end_of_process_n) && bus_owned |-> ##[1:3] eop_seen)
        else $error("end of process not flagged");
endmodule : dma_resp_sva

// *** dv/dma_far_model.sv ***
// Model of the peripheral, memory and arbiter beyond the channel
// Assumes strobes are held until access_done, one clock domain
`timescale 1ns/1ps
module dma_far_model
    import dma_resp_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire logic              slow,
    input  wire logic              bus_request,
    input  wire logic              bus_owned,
    input  wire logic              read_strobe,
    input  wire logic              write_strobe,
    input  wire logic [ADDR_W-1:0] bus_address,
    output logic                   bus_grant,
    output logic                   access_done,
    output logic [DATA_W-1:0]      read_data
);
    logic [1:0]        wait_cnt;
    logic              req_seen;
    logic [DATA_W-1:0] last_data;
    wire  logic        strobe = read_strobe | write_strobe;
    wire  logic [1:0]  lat    = slow ? 2'h3 : 2'h0;

    assign access_done = strobe && (wait_cnt == lat);
    // Released data lines show the inverse of the last value
    assign read_data   = read_strobe ? (bus_address[DATA_W-1:0] ^ 16'hA5C3) : ~last_data;

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            wait_cnt  <= 2'h0;
            req_seen  <= 1'b0;
            bus_grant <= 1'b0;
            last_data <= 16'h0000;
        end
        else
        begin
            req_seen  <= bus_request;
            bus_grant <= (bus_request && (!slow || req_seen)) || (bus_grant && bus_owned);
            wait_cnt  <= (strobe && !access_done) ? wait_cnt + 2'h1 : 2'h0;
            if (read_strobe)
                last_data <= read_data;
        end
    end
endmodule : dma_far_model

// *** dv/tb.sv ***
// Testbench: response modes, masking, demand levels, end of process
// Assumes controller, FIFO, package and far side model compiled first
`timescale 1ns/1ps
module tb;
    import dma_resp_pkg::*;
    typedef struct packed {
        logic [1:0] mode, op, fun;
        logic       fly, ack, pol, som, tc;
        logic [7:0] cnt, rd, wr, left;
    } row_t;
    row_t rows [8] = '{
        '{RESP_SINGLE, OP_TRANSFER, FUN_NONE, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 8'h03, 8'h01, 8'h01, 8'h02},
        '{RESP_BUS_HOLD, OP_TRANSFER, FUN_NONE, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 8'h03, 8'h03, 8'h03, 8'h00},
        '{RESP_BUS_REL, OP_TRANSFER, FUN_BYTE_WORD, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 8'h02, 8'h04, 8'h02, 8'h00},
        '{RESP_INTERLEAVE, OP_TRANSFER, FUN_WORD_BYTE, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 8'h02, 8'h02, 8'h04, 8'h00},
        '{RESP_INTERLEAVE, OP_TRANSFER_SRC, FUN_NONE, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 8'h02, 8'h02, 8'h02, 8'h00},
        '{RESP_BUS_REL, OP_TRANSFER, FUN_NONE, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 8'h02, 8'h02, 8'h00, 8'h00},
        '{RESP_BUS_REL, OP_SEARCH, FUN_NONE, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 8'h03, 8'h03, 8'h00, 8'h00},
        '{RESP_BUS_HOLD, OP_SEARCH, FUN_NONE, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 8'h03, 8'h01, 8'h00, 8'h02}};
    logic sys_clk = 1'b0, nrst = 1'b0, slow = 1'b0, master_release_policy_bit = 1'b0, sw_request = 1'b0;
    logic hw_mask = 1'b0, dma_request_n = 1'b1, end_of_process_n = 1'b1, load_strobe = 1'b0, other_req = 1'b0;
    logic bus_grant, access_done, bus_request, bus_owned, read_strobe, write_strobe, dma_acknowledge_n;
    logic idle_hold_state, count_exhausted, match_found, eop_seen, yield_to_other;
    logic [COUNT_W-1:0] count_load = 16'h0000, op_count;
    logic [ADDR_W-1:0]  bus_address, current_address_a, current_address_b;
    logic [DATA_W-1:0]  read_data;
    chan_cfg_t          cfg = '0;
    match_cfg_t         match_cfg = '0;
    int                 miscompares = 0, total_checks = 0, n_rd = 0, n_wr = 0, n_ack = 0, n_yield = 0;
    logic [31:0]        it, k;
    row_t               row;

    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
        if (nrst)
        begin
            n_rd += int'(read_strobe && access_done);
            n_wr += int'(write_strobe && access_done);
            n_ack += int'(!dma_acknowledge_n);
            n_yield += int'(yield_to_other);
        end

    dma_channel_request_response DUT (.sys_clk(sys_clk), .nrst(nrst), .cfg(cfg), .match_cfg(match_cfg),
        .master_release_policy_bit(master_release_policy_bit), .sw_request(sw_request),
        .chain_sets_sw_request(1'b0), .hw_mask(hw_mask), .interrupt_pending_hold(1'b0), .interrupt_ack(1'b0),
        .dma_request_n(dma_request_n), .end_of_process_n(end_of_process_n), .count_load(count_load),
        .addr_a_load(24'h001000), .addr_b_load(24'h008000), .load_strobe(load_strobe),
        .other_chan_request(other_req), .bus_grant(bus_grant), .access_done(access_done), .read_data(read_data),
        .bus_request(bus_request), .bus_owned(bus_owned), .read_strobe(read_strobe), .write_strobe(write_strobe),
        .bus_address(bus_address), .write_data(), .dma_acknowledge_n(dma_acknowledge_n),
        .idle_hold_state(idle_hold_state), .count_exhausted(count_exhausted), .match_found(match_found),
        .eop_seen(eop_seen), .reload_request(), .yield_to_other(yield_to_other), .op_count(op_count),
        .current_address_a(current_address_a), .current_address_b(current_address_b));
    dma_far_model u_far (.sys_clk(sys_clk), .nrst(nrst), .slow(slow), .bus_request(bus_request),
        .bus_owned(bus_owned), .read_strobe(read_strobe), .write_strobe(write_strobe),
        .bus_address(bus_address), .bus_grant(bus_grant), .access_done(access_done), .read_data(read_data));

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic start(input logic [1:0] mode, input logic [7:0] n);
        @(posedge sys_clk);
        cfg <= '{mode, OP_TRANSFER, FUN_NONE, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
        count_load <= {8'h00, n};
        load_strobe <= 1'b1;
        @(posedge sys_clk);
        load_strobe <= 1'b0;
        n_rd = 0;
        n_wr = 0;
    endtask : start
    task automatic sw_go;
        @(posedge sys_clk);
        sw_request <= 1'b1;
        @(posedge sys_clk);
        sw_request <= 1'b0;
    endtask : sw_go
    task automatic wait_idle;
        int quiet;
        quiet = 0;
        for (int i = 0; i < 3000 && quiet < 8; i++)
        begin
            @(negedge sys_clk);
            quiet = (bus_owned || bus_request) ? 0 : quiet + 1;
        end
        if (quiet < 8)
        begin
            miscompares++;
            test_done();
        end
    endtask : wait_idle
    task automatic wait_reads(input int n);
        for (int i = 0; i < 500 && n_rd < n; i++)
            @(negedge sys_clk);
        if (n_rd < n)
        begin
            miscompares++;
            test_done();
        end
        @(posedge sys_clk);
    endtask : wait_reads

    initial
    begin
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        @(negedge sys_clk);
        check(dma_acknowledge_n, 1);
        check(bus_request, 0);
        check(op_count, 0);
        for (int r = 0; r < 8; r++)
        begin
            row = rows[r];
            start(row.mode, row.cnt);
            cfg <= '{row.mode, row.op, row.fun, row.fly, row.ack, 1'b1, row.op != OP_SEARCH, 1'b0, 1'b0};
            match_cfg <= '{16'h0000, 16'hFFFF, row.som};
            master_release_policy_bit <= row.pol;
            other_req <= row.ack;
            slow <= r[0];
            n_ack = 0;
            n_yield = 0;
            sw_go();
            wait_idle();
            it = 32'(row.cnt - row.left);
            check(n_rd, row.rd);
            check(n_wr, row.wr);
            check(op_count, row.left);
            check(count_exhausted, row.tc);
            check(match_found, row.som);
            check(bus_owned, 0);
            if (row.fun == FUN_NONE) check(current_address_a, 32'h1000 + it);
            if (row.fun == FUN_NONE) check(current_address_b, 32'h8000 + (row.op == OP_SEARCH ? 0 : it));
            if (row.ack) check(n_ack, row.fly ? row.rd : 0);
            check(n_yield, (row.mode == RESP_INTERLEAVE && !row.pol && row.ack) ? row.cnt : 8'h00);
            $display("row %0d done", r);
        end
        start(RESP_SINGLE, 8'h03);
        hw_mask <= 1'b1;
        dma_request_n <= 1'b0;
        repeat (20) @(negedge sys_clk);
        check(bus_request, 0);
        @(posedge sys_clk);
        dma_request_n <= 1'b1;
        hw_mask <= 1'b0;
        wait_idle();
        check(op_count, 2);
        @(posedge sys_clk);
        dma_request_n <= 1'b0;
        wait_idle();
        check(op_count, 1);
        dma_request_n <= 1'b1;
        $display("mask test done");
        start(RESP_BUS_HOLD, 8'h04);
        dma_request_n <= 1'b0;
        wait_reads(1);
        dma_request_n <= 1'b1;
        for (int i = 0; i < 200 && !idle_hold_state; i++)
            @(negedge sys_clk);
        check({idle_hold_state, bus_owned}, 3);
        k = 32'(op_count);
        repeat (10) @(negedge sys_clk);
        check(op_count, k);
        sw_go();
        wait_idle();
        check(count_exhausted, 1);
        $display("hold test done");
        start(RESP_BUS_REL, 8'h64);
        sw_go();
        wait_reads(2);
        end_of_process_n <= 1'b0;
        @(posedge sys_clk);
        end_of_process_n <= 1'b1;
        wait_idle();
        check(eop_seen, 1);
        check(count_exhausted, 0);
        check(n_wr, n_rd);
        start(RESP_BUS_REL, 8'h32);
        dma_request_n <= 1'b0;
        wait_reads(3);
        dma_request_n <= 1'b1;
        wait_idle();
        check(op_count, 50 - n_wr);
        $display("release tests done");
        start(RESP_BUS_HOLD, 8'h32);
        sw_go();
        wait_reads(1);
        nrst <= 1'b0;
        repeat (3) @(negedge sys_clk);
        check(dma_acknowledge_n, 1);
        check(op_count, 0);
        $display("reset test done");
        test_done();
    end
endmodule : tb

bind dma_channel_request_response dma_resp_sva u_sva (.sys_clk(sys_clk), .nrst(nrst), .cfg(cfg),
    .load_strobe(load_strobe), .dma_request_n(dma_request_n), .end_of_process_n(end_of_process_n),
    .bus_owned(bus_owned), .read_strobe(read_strobe), .write_strobe(write_strobe),
    .dma_acknowledge_n(dma_acknowledge_n), .idle_hold_state(idle_hold_state),
    .count_exhausted(count_exhausted), .eop_seen(eop_seen), .op_count(op_count));
